// [common/smc_pkg.sv]
// package for the slave mezzanine control register bank
package smc_pkg;
  // register indices (word addresses on the slave register port)
  localparam logic [3:0] ADDR_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam logic [3:0] ADDR_BUS_SEL = 4'h6;
  localparam logic [3:0] ADDR_CAUSE = 4'h7;
  localparam logic [3:0] ADDR_DATE = 4'h8;
  localparam logic [3:0] ADDR_MASK = 4'h9;
  localparam logic [3:0] ADDR_CALIB = 4'hA;
  // control field positions
  localparam int CTRL_STATIC_BIT = 3;
  localparam int CTRL_EXTCLK_BIT = 2;
  localparam int CTRL_EXTRST_BIT = 1;
  localparam int CTRL_GRST_BIT = 0;
  // status and cause field positions
  localparam int STAT_ROLE_BIT = 0;
  localparam int CAUSE_FRAME_BIT = 0;
  localparam int CAUSE_NOACK_BIT = 1;
  localparam int CAUSE_USER_BIT = 2;
  localparam int CAUSE_PIN_LSB = 8;
  // reset values
  localparam logic [3:0] CONTROL_RST = 4'h0;
  localparam logic [15:0] BUS_SEL_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [7:0] CALIB_RST = 8'h00;
  localparam logic [15:0] DATE_DEFAULT = 16'h0101; // arbitrary build date, MMDD
  // calibration delay step
  localparam int CALIB_STEP_NS = 25;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CALIB_STEP_CYC = (CALIB_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // calibration delay states
  typedef enum logic [1:0] {SMC_CAL_IDLE, SMC_CAL_WAIT, SMC_CAL_FIRE} smc_cal_state_t;
endpackage

// [hdl/smc_calib_delay.sv]
// delayed one-cycle calibration pulse generator
`timescale 1ns/1ns
module smc_calib_delay
  import smc_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // control
  input wire logic [7:0] i_delay,
  input wire logic i_trig,
  // pulse out
  output logic o_pulse
);
  smc_cal_state_t state_ff; // sequencer state
  logic [7:0] steps_ff; // remaining 25 ns steps
  logic [7:0] sub_ff; // cycles inside a step

  // sequencer: a new trigger while busy is ignored, pulses never overlap
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_ff <= SMC_CAL_IDLE;
      steps_ff <= 8'h00;
      sub_ff <= 8'h00;
    end
    else
    begin
      case (state_ff)
        SMC_CAL_IDLE:
        begin
          if (i_trig)
          begin
            steps_ff <= i_delay;
            sub_ff <= 8'(CALIB_STEP_CYC - 1);
            // zero delay fires on the next cycle
            state_ff <= (i_delay == 8'h00) ? SMC_CAL_FIRE : SMC_CAL_WAIT;
          end
        end
        SMC_CAL_WAIT:
        begin
          // count delay times step cycles
          if (sub_ff != 8'h00)
          begin
            sub_ff <= sub_ff - 8'h01;
          end
          else if (steps_ff == 8'h01)
          begin
            state_ff <= SMC_CAL_FIRE;
          end
          else
          begin
            steps_ff <= steps_ff - 8'h01;
            sub_ff <= 8'(CALIB_STEP_CYC - 1);
          end
        end
        SMC_CAL_FIRE:
        begin
          state_ff <= SMC_CAL_IDLE;
        end
        default:
        begin
          state_ff <= SMC_CAL_IDLE;
        end
      endcase
    end
  end

  // exactly one clock of pulse
  assign o_pulse = (state_ff == SMC_CAL_FIRE);
endmodule

// [hdl/smc_regs.sv]
// slave mezzanine control and status register bank
`timescale 1ns/1ns
module smc_regs
  import smc_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_switch_rst,
  // register port driven by the frame decoder
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  // frame-driven enables
  input wire logic [15:0] i_dyn_driver_enable,
  input wire logic [15:0] i_dyn_receiver_enable,
  output logic [15:0] o_bus_driver_enable_lines,
  output logic [15:0] o_bus_receiver_enable_lines,
  // clock and reset controls
  output logic o_ext_clk_sel,
  output logic o_local_osc_en,
  output logic o_ext_reset,
  output logic o_global_reset,
  // role
  input wire logic i_role_slave,
  output logic o_forward_bus,
  // event sources
  input wire logic i_frame_check_err,
  input wire logic i_i2c_no_ack,
  input wire logic i_user_int,
  input wire logic [7:0] i_pin_int,
  output logic o_slave_int,
  // calibration
  input wire logic i_calibration_pulse_type0,
  output logic o_calib_pulse,
  // configurable pins
  output logic [31:0] o_pin_oe
);
  // word map of the bank on the slave register port:
  //   control, status, static selection, event cause, build date,
  //   event mask and calibration delay, in rising index order;
  //   lower indices belong to pin registers kept outside this bank

  // register storage, one flop group per register
  logic [3:0] control_ff; // mezzanine_control
  logic [15:0] bus_sel_ff; // bus_select_static
  logic [15:0] mask_ff; // event_mask
  logic [7:0] calib_ff; // calib_delay
  logic [15:0] cause_ff; // event_cause, sticky low byte
  logic [15:0] rdata_ff; // registered read data
  // next values, worked out combinationally
  logic [3:0] nxt_control; // control after this edge
  logic [15:0] nxt_bus_sel; // selection after this edge
  logic [15:0] nxt_mask; // mask after this edge
  logic [7:0] nxt_calib; // delay after this edge
  logic [15:0] nxt_cause; // raw events this cycle
  logic [15:0] nxt_rdata; // read mux output
  // decoded strobes and constants
  logic cause_rd; // the cause register is read this cycle
  logic [15:0] build_date_code; // constant date

  // true when a strobe targets one register index; every write and the
  // cause clear share this one decode, so they can never disagree on
  // which word a frame meant
  function automatic logic reg_hit(input logic strobe, input logic [3:0] addr,
                                   input logic [3:0] idx);
    reg_hit = strobe && (addr == idx);
  endfunction

  assign build_date_code = DATE_DEFAULT;
  assign cause_rd = reg_hit(i_rd, i_addr, ADDR_CAUSE);

  // control next value; only the four defined bits are stored
  // a write to any other index leaves it untouched
  always_comb
  begin
    nxt_control = control_ff;
    if (reg_hit(i_wr, i_addr, ADDR_CONTROL))
    begin
      nxt_control = i_wdata[3:0];
    end
  end

  // control flops; clockless access is modelled by plain flops, so a write
  // lands on the edge that samples its strobe
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // local oscillator, dynamic enables, both resets off
      control_ff <= CONTROL_RST;
    end
    else
    begin
      control_ff <= nxt_control;
    end
  end

  // static selection next value; it only matters in static mode
  always_comb
  begin
    nxt_bus_sel = bus_sel_ff;
    if (reg_hit(i_wr, i_addr, ADDR_BUS_SEL))
    begin
      nxt_bus_sel = i_wdata;
    end
  end

  // static selection flops; cleared so a switch to static mode before any
  // write enables no driver
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bus_sel_ff <= BUS_SEL_RST;
    end
    else
    begin
      bus_sel_ff <= nxt_bus_sel;
    end
  end

  // mask next value; bits 7:3 have no cause behind them and stay zero
  always_comb
  begin
    nxt_mask = mask_ff;
    if (reg_hit(i_wr, i_addr, ADDR_MASK))
    begin
      nxt_mask = {i_wdata[15:8], 5'h00, i_wdata[2:0]};
    end
  end

  // mask flops; all causes are blocked after reset, so no interrupt can
  // rise before software has chosen what it wants to hear about
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mask_ff <= MASK_RST;
    end
    else
    begin
      mask_ff <= nxt_mask;
    end
  end

  // calibration delay next value, low byte only
  always_comb
  begin
    nxt_calib = calib_ff;
    if (reg_hit(i_wr, i_addr, ADDR_CALIB))
    begin
      nxt_calib = i_wdata[7:0];
    end
  end

  // calibration delay flops; a change while a delay runs only affects the
  // next trigger, since the sequencer copies the count at its start
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      calib_ff <= CALIB_RST;
    end
    else
    begin
      calib_ff <= nxt_calib;
    end
  end

  // raw event vector gated by the mask; a cause whose mask bit is clear
  // never reaches the sticky register, so it cannot raise the interrupt
  always_comb
  begin
    nxt_cause = 16'h0000;
    nxt_cause[CAUSE_FRAME_BIT] = i_frame_check_err & mask_ff[CAUSE_FRAME_BIT];
    nxt_cause[CAUSE_NOACK_BIT] = i_i2c_no_ack & mask_ff[CAUSE_NOACK_BIT];
    // user interrupt pin, enabled by its own mask bit
    nxt_cause[CAUSE_USER_BIT] = i_user_int & mask_ff[CAUSE_USER_BIT];
    // pin-vector causes track the pin level
    nxt_cause[15:8] = i_pin_int & mask_ff[15:8];
  end

  // sticky low causes; a read clears them but a same-cycle event survives,
  // so an event is never lost between the read and the clear
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cause_ff <= 16'h0000;
    end
    else if (cause_rd)
    begin
      cause_ff <= nxt_cause;
    end
    else
    begin
      // low bits accumulate, pin bits follow the pins
      cause_ff <= {nxt_cause[15:8], cause_ff[7:0] | nxt_cause[7:0]};
    end
  end

  // read mux; the cause read returns the pending value, then clears it
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (i_rd)
    begin
      case (i_addr)
        ADDR_CONTROL: nxt_rdata = {12'h000, control_ff};
        ADDR_STATUS: nxt_rdata = {15'h0000, i_role_slave};
        ADDR_BUS_SEL: nxt_rdata = bus_sel_ff;
        ADDR_CAUSE: nxt_rdata = cause_ff;
        ADDR_DATE: nxt_rdata = build_date_code;
        ADDR_MASK: nxt_rdata = mask_ff;
        ADDR_CALIB: nxt_rdata = {8'h00, calib_ff};
        // unmapped words and the pin registers kept elsewhere read zero
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  // read data flops; the word holds until the next read, so a slow frame
  // encoder may pick it up late
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_ff <= 16'h0000;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign o_rdata = rdata_ff;

  // driver enables: static from selection, else frame-driven
  // a plain mux, so a mode change acts on the very next cycle
  assign o_bus_driver_enable_lines = control_ff[CTRL_STATIC_BIT] ? bus_sel_ff
                                                                  : i_dyn_driver_enable;
  // receiver enables never static; the selection register has no path
  // to them in any mode
  assign o_bus_receiver_enable_lines = i_dyn_receiver_enable;

  // clock source; external choice stops the local oscillator
  // both outputs come from one flop, so they can never both be active
  assign o_ext_clk_sel = control_ff[CTRL_EXTCLK_BIT];
  assign o_local_osc_en = ~control_ff[CTRL_EXTCLK_BIT];

  // resets are combinational so they need no clock edge to assert;
  // the software global reset also reaches the external reset pin
  // limitation: the global reset does not clear this bank itself, or the
  // bit that requests it would be wiped before it could be seen
  assign o_global_reset = control_ff[CTRL_GRST_BIT] | i_switch_rst;
  assign o_ext_reset = control_ff[CTRL_EXTRST_BIT] | o_global_reset;

  // role low: act as master and forward the bus locally
  // the role pin is a strap, so it is passed on without a flop
  assign o_forward_bus = ~i_role_slave;

  // interrupt request is the OR of every pending cause bit
  assign o_slave_int = |cause_ff;

  // pins stay inputs; pin configuration lives outside this bank, so this
  // bank never drives any of them
  assign o_pin_oe = 32'h0000_0000;

  // delayed calibration pulse; the sequencer runs on i_mclk, which stands
  // for the selected mezzanine clock here, and ignores triggers while busy
  // limitation: the step is rounded up to whole clock periods
  smc_calib_delay u_calib
  (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_delay(calib_ff),
    .i_trig(i_calibration_pulse_type0),
    .o_pulse(o_calib_pulse)
  );
endmodule

// [test/smc_assertions.sv]
// port checker for the mezzanine register bank
`timescale 1ns/1ns
module smc_assertions
  import smc_pkg::*;
(
  // all ports of the bank, watched only
  input wire logic i_mclk, i_rst_n, i_switch_rst, i_wr, i_rd,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata, o_rdata, i_dyn_driver_enable, i_dyn_receiver_enable,
  input wire logic [15:0] o_bus_driver_enable_lines, o_bus_receiver_enable_lines,
  input wire logic o_ext_clk_sel, o_local_osc_en, o_ext_reset, o_global_reset,
  input wire logic i_role_slave, o_forward_bus, i_frame_check_err, i_i2c_no_ack,
  input wire logic i_user_int, o_slave_int, i_calibration_pulse_type0, o_calib_pulse,
  input wire logic [7:0] i_pin_int,
  input wire logic [31:0] o_pin_oe
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  a_osc_exclusive: assert property (o_local_osc_en != o_ext_clk_sel)
    else $error("oscillator enable not inverse of select");
  a_ext_rst_or: assert property (o_global_reset |-> o_ext_reset)
    else $error("external reset misses global reset");
  a_switch_rst: assert property (i_switch_rst |-> o_global_reset)
    else $error("switch reset not passed on");
  a_rx_dynamic: assert property (o_bus_receiver_enable_lines == i_dyn_receiver_enable)
    else $error("receiver enables not frame driven");
  a_role_fwd: assert property (o_forward_bus != i_role_slave)
    else $error("forwarding does not follow role");
  a_pins_input: assert property (o_pin_oe == 32'h0)
    else $error("pin driven without configuration");
  a_calib_single: assert property (o_calib_pulse |=> !o_calib_pulse)
    else $error("calibration pulse longer than one cycle");
  a_date_read: assert property (i_rd && i_addr == ADDR_DATE |=> o_rdata == DATE_DEFAULT)
    else $error("build date read wrong");
  a_role_read: assert property (i_rd && i_addr == ADDR_STATUS |=> o_rdata[0] == $past(i_role_slave))
    else $error("status role bit wrong");
  // main scenarios reached
  c_calib: cover property (o_calib_pulse);
  c_static: cover property (o_bus_driver_enable_lines != i_dyn_driver_enable);
  c_irq: cover property (o_slave_int);
endmodule

// [test/smc_master_model.sv]
// remote frame master issuing register accesses to the slave bank
`timescale 1ns/1ns
module smc_master_model
(
  // clock and answer
  input wire logic i_mclk,
  input wire logic [15:0] i_rdata,
  // request strobes
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic [3:0] o_addr = 4'h0,
  output logic [15:0] o_wdata = 16'h0000
);
  // only this master starts transfers, one strobe cycle each
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge i_mclk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= v;
    @(posedge i_mclk);
    o_wr <= 1'b0;
    o_wdata <= ~v;
  endtask
  // answer stands after the read edge, taken mid-cycle
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge i_mclk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    @(negedge i_mclk);
    v = i_rdata;
  endtask
endmodule

// [test/tb_top.sv]
// self-checking bench for the mezzanine register bank
`timescale 1ns/1ns
module tb_top
  import smc_pkg::*;
  ;
  // design inputs, all given a value at time zero
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_switch_rst = 1'b0, i_role_slave = 1'b1;
  logic i_frame_check_err = 1'b0, i_i2c_no_ack = 1'b0, i_user_int = 1'b0;
  logic i_calibration_pulse_type0 = 1'b0, i_wr, i_rd;
  logic [3:0] i_addr;
  logic [7:0] i_pin_int = 8'h00;
  logic [15:0] i_wdata, o_rdata, d, i_dyn_driver_enable = 16'h3C5A;
  logic [15:0] i_dyn_receiver_enable = 16'h0FF0, o_bus_driver_enable_lines;
  logic [15:0] o_bus_receiver_enable_lines;
  logic o_ext_clk_sel, o_local_osc_en, o_ext_reset, o_global_reset;
  logic o_forward_bus, o_slave_int, o_calib_pulse;
  logic [31:0] o_pin_oe;
  int fails = 0, samples_checked = 0, n, w;
  always #5 i_mclk = ~i_mclk;
  smc_regs u_dut (.*);
  smc_master_model u_mst (.i_mclk, .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd),
    .o_addr(i_addr), .o_wdata(i_wdata));
  // compare with case equality so an unknown never matches a known value
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    u_mst.rd_reg(ADDR_CONTROL, d);
    chk("ctrl rst", d, CONTROL_RST);
    @(posedge i_mclk);
    i_switch_rst <= 1'b1;
    @(negedge i_mclk);
    chk("sw rst", o_global_reset, 1'b1);
    @(posedge i_mclk);
    i_switch_rst <= 1'b0;
    // each control bit alone; loop leaves static mode selected
    for (n = 0; n < 4; n++)
    begin
      u_mst.wr_reg(ADDR_CONTROL, 16'h1 << n);
      @(negedge i_mclk);
      chk("clk sel", o_ext_clk_sel, n == 2);
      chk("osc en", o_local_osc_en, n != 2);
      chk("ext rst", o_ext_reset, n < 2);
      chk("glb rst", o_global_reset, n == 0);
      chk("drv", o_bus_driver_enable_lines, n == 3 ? BUS_SEL_RST : i_dyn_driver_enable);
      u_mst.rd_reg(ADDR_CONTROL, d);
      chk("ctrl rd", d, 16'h1 << n);
    end
    u_mst.wr_reg(ADDR_BUS_SEL, 16'hA5C3);
    @(negedge i_mclk);
    chk("drv static", o_bus_driver_enable_lines, 16'hA5C3);
    chk("rcv", o_bus_receiver_enable_lines, i_dyn_receiver_enable);
    u_mst.wr_reg(ADDR_CONTROL, 16'h0000);
    @(negedge i_mclk);
    chk("drv dyn", o_bus_driver_enable_lines, i_dyn_driver_enable);
    $display("control test done");
    for (n = 0; n < 2; n++)
    begin
      @(posedge i_mclk);
      i_role_slave <= n[0];
      u_mst.rd_reg(ADDR_STATUS, d);
      chk("role", d[0], n[0]);
      chk("fwd", o_forward_bus, !n[0]);
    end
    // all three single-bit sources fire, only one is unmasked each round
    for (n = 0; n < 3; n++)
    begin
      u_mst.wr_reg(ADDR_MASK, 16'h1 << n);
      {i_user_int, i_i2c_no_ack, i_frame_check_err} <= 3'h7;
      @(posedge i_mclk);
      {i_user_int, i_i2c_no_ack, i_frame_check_err} <= 3'h0;
      @(negedge i_mclk);
      chk("irq set", o_slave_int, 1'b1);
      u_mst.rd_reg(ADDR_CAUSE, d);
      chk("cause", d, 16'h1 << n);
      chk("irq clr", o_slave_int, 1'b0);
    end
    u_mst.wr_reg(ADDR_MASK, 16'hFF00);
    i_pin_int <= 8'h81;
    u_mst.rd_reg(ADDR_CAUSE, d);
    chk("pin cause", d[15:8], 8'h81);
    u_mst.wr_reg(ADDR_DATE, 16'h1234);
    u_mst.rd_reg(ADDR_DATE, d);
    chk("date", d, DATE_DEFAULT);
    $display("event test done");
    // shortest nonzero and longest delay count
    for (n = 0; n < 2; n++)
    begin
      u_mst.wr_reg(ADDR_CALIB, n ? 16'h00FF : 16'h0001);
      i_calibration_pulse_type0 <= 1'b1;
      @(posedge i_mclk);
      i_calibration_pulse_type0 <= 1'b0;
      w = 0;
      do
      begin
        @(posedge i_mclk);
        #1 w++;
      end while (!o_calib_pulse && w < 1000);
      chk("cal delay", w, CALIB_STEP_CYC * (n ? 255 : 1));
      if (w == 1000)
        finish_test();
      @(posedge i_mclk);
      #1 chk("cal width", o_calib_pulse, 1'b0);
    end
    $display("calibration test done");
    finish_test();
  end
endmodule
bind smc_regs smc_assertions u_chk (.*);
